// file: hdl/fpcd_pkg.sv
// Constants, field positions and state type for the front panel configuration command decoder
package fpcd_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int GPIO_MIN_PULSE_NS = 8000;
    localparam int GPIO_FILT_CYC = (GPIO_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GUARD_SECOND_MS = 1000;
    localparam int GUARD_SECOND_CYC = GUARD_SECOND_MS * 1000000 / CLK_PERIOD_NS;

    // Command byte decode
    localparam int CMD_TOP_HI = 7;
    localparam int CMD_TOP_LO = 6;
    localparam logic [1:0] CMD_CONFIG = 2'h0;
    localparam logic [1:0] CMD_DATA = 2'h1;

    // Configuration command bits
    localparam int CFG_WAKE_BIT = 5;
    localparam int CFG_DIGCHG_BIT = 4;
    localparam int CFG_CLKDISP_BIT = 3;
    localparam int CFG_RCHOT_BIT = 2;
    localparam int CFG_FPHOT_BIT = 1;
    localparam int CFG_GSTBY_BIT = 0;

    // First setting byte
    localparam int S1_RAW_BIT = 7;
    localparam int S1_PROTO_HI = 6;
    localparam int S1_PROTO_LO = 4;
    localparam int S1_GUARD_HI = 3;
    localparam int S1_GUARD_LO = 0;

    // Second setting byte
    localparam int S2_DIG_HI = 1;
    localparam int S2_DIG_LO = 0;
    localparam int S2_PP_BIT = 2;
    localparam int S2_DIR0_BIT = 3;
    localparam int S2_IRQEN_BIT = 5;
    localparam int S2_EDGE0_BIT = 6;

    // Reset values
    localparam logic [2:0] PROTO_RST = 3'h2;
    localparam logic [3:0] GUARD_RST = 4'hA;
    localparam logic [3:0] GUARD_OFF = 4'h0;
    localparam logic [1:0] DIGITS_RST = 2'h3;

    // Key matrix and general pins
    localparam int KEY_LINES = 8;
    localparam int KEY_BYTES = 2;
    localparam int GPIO_PINS = 2;

    typedef enum {
        FPCD_IDLE,
        FPCD_CMD,
        FPCD_CFG1,
        FPCD_CFG2,
        FPCD_SKIP
    } fpcd_state_t;
endpackage

// file: hdl/fpcd_key_store.sv
// Two-byte key matrix store with registered read port
`timescale 1ns/1ps
module fpcd_key_store #(
    parameter int LINES = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wrEn,
    input wire logic [$clog2(LINES)-1:0] wrLine,
    input wire logic wrA,
    input wire logic wrB,
    input wire logic clear,
    input wire logic rdEn,
    input wire logic rdAddr,
    output logic [7:0] rdData
);
    logic [7:0] mem [0:1];
    logic memByte;
    logic [2:0] bitPos;

    // Four lines per byte, return A on even bit, return B on the odd bit above it
    assign memByte = wrLine[$clog2(LINES)-1];
    assign bitPos = {wrLine[1:0], 1'b0};

    always_ff @(posedge clk) begin
        if (!rst_b || clear) begin
            mem[0] <= 8'h00;
            mem[1] <= 8'h00;
        end else if (wrEn) begin
            mem[memByte][bitPos] <= wrA;
            mem[memByte][bitPos + 3'h1] <= wrB;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdData <= 8'h00;
        end else if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end
endmodule // fpcd_key_store

// file: hdl/fpcd_front_panel_decoder.sv
// Command decoder for the configuration mode command and its settings
//
// Contract
// - Key matrix kept as two bytes, returns A/B alternate per line, read LSB first.
// - Hot key data cleared if unread when guard time elapses after standby release.
// - Configuration bit makes all front keys hot; else a separate 16-key mask applies.
// - First byte after slave address is taken as a command.
// - Bytes without preceding slave address ignored; earlier settings stay valid.
// - Digit count change switches display off until display-on; same mode changes nothing.
// - Top bits 00 decode as configuration mode setting command.
// - Bit 5 enables external wake, bit 4 enables digit count change.
// - Bit3 clock display, bit2 remote hot keys, bit1 front hot keys, bit0 guard standby.
// - Clock display in normal mode blanks while host writes on the bus.
// - First setting bits 6..4 select remote protocol; 000 disables decoding.
// - First setting bit 7 low gives decoded remote frame output.
// - First setting bit 7 high gives raw remote output, address still decoded.
// - First setting bits 3..0 give guard period in seconds; 0000 disables.
// - Second setting bits 1..0 enable one to four digits.
// - Second setting bit 2 selects push-pull outputs, clear means open-drain.
// - Second setting bits 3 and 4 set pin directions, 1 is output.
// - Second setting bit 5 enables interrupts on general pin input changes.
// - Second setting bits 6 and 7 pick edge per pin: 0 falling, 1 rising.
// - Reset gives four digits, display off, scan on, protocol 2, guard standby.
// - Guard runs 10 s from reset; first processed command turns it off.
// - Top bits 01 decode as data setting command.
`timescale 1ns/1ps
module fpcd_front_panel_decoder #(
    parameter int SECOND_CYC = fpcd_pkg::GUARD_SECOND_CYC,
    parameter int FILT_CYC = fpcd_pkg::GPIO_FILT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic slaveAddrMatch,
    input wire logic rxByteValid,
    input wire logic [7:0] rxByte,
    input wire logic stopSeen,
    input wire logic displayOnReq,
    input wire logic standbyReq,
    input wire logic wakeReq,
    input wire logic [15:0] hotKeyMask,
    input wire logic keyScanStrobe,
    input wire logic [2:0] keyScanLine,
    input wire logic key_return_input_a,
    input wire logic key_return_input_b,
    input wire logic keyReadEn,
    input wire logic keyReadAddr,
    output logic [7:0] keyReadData,
    input wire logic general_pin_zero_in,
    input wire logic general_pin_one_in,
    input wire logic [1:0] gpioOutData,
    output logic general_pin_zero_out,
    output logic general_pin_one_out,
    output logic general_pin_zero_oe_b,
    output logic general_pin_one_oe_b,
    output logic gpioIrq,
    output logic dataCmdStrobe,
    output logic [5:0] dataCmdBits,
    output logic host_standby_line,
    output logic wakePinEn,
    output logic clockDisplayEn,
    output logic clockDisplayBlank,
    output logic remoteHotKeys,
    output logic [15:0] frontHotKeyEn,
    output logic guardStandbyEn,
    output logic [2:0] remoteProtocol,
    output logic remoteRawFormat,
    output logic [3:0] guardPeriod,
    output logic [1:0] digitCount,
    output logic displayOn,
    output logic keyScanOn,
    output logic pushPullOut,
    output logic [1:0] gpioDirOut,
    output logic gpioIrqEn,
    output logic [1:0] gpioRiseEdge
);
    fpcd_pkg::fpcd_state_t state;
    logic digitChangeEn;
    logic frontHotAll;
    logic firstCmdDone;
    logic [31:0] secCnt;
    logic secTick;
    logic [3:0] guardCnt;
    logic guardExpire;
    logic standbyPrev;
    logic standbyRelease;
    logic hotKeyPending;
    logic hotKeyClear;
    logic cmdTaken;
    logic [1:0] pinRaw;
    logic [1:0] pinEdge;

    // Command sequencing; a byte sharing its cycle with an address or a stop is refused
    assign cmdTaken = (state == fpcd_pkg::FPCD_CMD) && rxByteValid && !slaveAddrMatch && !stopSeen;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= fpcd_pkg::FPCD_IDLE;
        end else if (stopSeen) begin
            state <= fpcd_pkg::FPCD_IDLE;
        end else if (slaveAddrMatch) begin
            state <= fpcd_pkg::FPCD_CMD;
        end else if (rxByteValid) begin
            case (state)
                fpcd_pkg::FPCD_IDLE: begin
                    state <= fpcd_pkg::FPCD_IDLE;
                end
                fpcd_pkg::FPCD_CMD: begin
                    if (rxByte[fpcd_pkg::CMD_TOP_HI:fpcd_pkg::CMD_TOP_LO] == fpcd_pkg::CMD_CONFIG) begin
                        state <= fpcd_pkg::FPCD_CFG1;
                    end else begin
                        state <= fpcd_pkg::FPCD_SKIP;
                    end
                end
                fpcd_pkg::FPCD_CFG1: begin
                    state <= fpcd_pkg::FPCD_CFG2;
                end
                default: begin
                    state <= fpcd_pkg::FPCD_SKIP;
                end
            endcase
        end
    end

    // Data setting commands are passed on, not interpreted here
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dataCmdStrobe <= 1'b0;
            dataCmdBits <= 6'h00;
        end else begin
            dataCmdStrobe <= cmdTaken &&
                (rxByte[fpcd_pkg::CMD_TOP_HI:fpcd_pkg::CMD_TOP_LO] == fpcd_pkg::CMD_DATA);
            if (cmdTaken) begin
                dataCmdBits <= rxByte[5:0];
            end
        end
    end

    // Configuration command byte
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wakePinEn <= 1'b0;
            digitChangeEn <= 1'b0;
            clockDisplayEn <= 1'b0;
            remoteHotKeys <= 1'b0;
            frontHotAll <= 1'b0;
            guardStandbyEn <= 1'b1;
        end else if (cmdTaken &&
                     rxByte[fpcd_pkg::CMD_TOP_HI:fpcd_pkg::CMD_TOP_LO] == fpcd_pkg::CMD_CONFIG) begin
            wakePinEn <= rxByte[fpcd_pkg::CFG_WAKE_BIT];
            digitChangeEn <= rxByte[fpcd_pkg::CFG_DIGCHG_BIT];
            clockDisplayEn <= rxByte[fpcd_pkg::CFG_CLKDISP_BIT];
            remoteHotKeys <= rxByte[fpcd_pkg::CFG_RCHOT_BIT];
            frontHotAll <= rxByte[fpcd_pkg::CFG_FPHOT_BIT];
            guardStandbyEn <= rxByte[fpcd_pkg::CFG_GSTBY_BIT];
        end
    end

    assign frontHotKeyEn = frontHotAll ? 16'hFFFF : hotKeyMask;

    // First setting byte; any first command also stops the power-up guard run
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            remoteProtocol <= fpcd_pkg::PROTO_RST;
            remoteRawFormat <= 1'b0;
            guardPeriod <= fpcd_pkg::GUARD_RST;
            firstCmdDone <= 1'b0;
        end else if (state == fpcd_pkg::FPCD_CFG1 && rxByteValid && !slaveAddrMatch && !stopSeen) begin
            remoteRawFormat <= rxByte[fpcd_pkg::S1_RAW_BIT];
            remoteProtocol <= rxByte[fpcd_pkg::S1_PROTO_HI:fpcd_pkg::S1_PROTO_LO];
            guardPeriod <= rxByte[fpcd_pkg::S1_GUARD_HI:fpcd_pkg::S1_GUARD_LO];
        end else if (cmdTaken && !firstCmdDone) begin
            guardPeriod <= fpcd_pkg::GUARD_OFF;
            firstCmdDone <= 1'b1;
        end
    end

    // Second setting byte
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pushPullOut <= 1'b0;
            gpioDirOut <= 2'h0;
            gpioIrqEn <= 1'b0;
            gpioRiseEdge <= 2'h0;
        end else if (state == fpcd_pkg::FPCD_CFG2 && rxByteValid && !slaveAddrMatch && !stopSeen) begin
            pushPullOut <= rxByte[fpcd_pkg::S2_PP_BIT];
            gpioDirOut <= rxByte[fpcd_pkg::S2_DIR0_BIT +: fpcd_pkg::GPIO_PINS];
            gpioIrqEn <= rxByte[fpcd_pkg::S2_IRQEN_BIT];
            gpioRiseEdge <= rxByte[fpcd_pkg::S2_EDGE0_BIT +: fpcd_pkg::GPIO_PINS];
        end
    end

    // Digit count and display on; a change of mode blanks until display-on
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            digitCount <= fpcd_pkg::DIGITS_RST;
            displayOn <= 1'b0;
        end else if (state == fpcd_pkg::FPCD_CFG2 && rxByteValid && !slaveAddrMatch && !stopSeen &&
                     digitChangeEn &&
                     rxByte[fpcd_pkg::S2_DIG_HI:fpcd_pkg::S2_DIG_LO] != digitCount) begin
            digitCount <= rxByte[fpcd_pkg::S2_DIG_HI:fpcd_pkg::S2_DIG_LO];
            displayOn <= 1'b0;
        end else if (displayOnReq) begin
            displayOn <= 1'b1;
        end
    end

    // Scan never switched off by this block
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            keyScanOn <= 1'b1;
        end else begin
            keyScanOn <= 1'b1;
        end
    end

    // Blanking uses the transfer state, so it also covers bytes of other commands
    assign clockDisplayBlank = clockDisplayEn && !host_standby_line &&
                               (state != fpcd_pkg::FPCD_IDLE);

    // One second tick from the system clock
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            secCnt <= 32'h0;
            secTick <= 1'b0;
        end else if (secCnt == 32'(SECOND_CYC - 1)) begin
            secCnt <= 32'h0;
            secTick <= 1'b1;
        end else begin
            secCnt <= secCnt + 32'h1;
            secTick <= 1'b0;
        end
    end

    // Guard timer, restarted on new period and on standby release
    assign guardExpire = secTick && (guardPeriod != fpcd_pkg::GUARD_OFF) &&
                         (guardCnt + 4'h1 == guardPeriod);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            guardCnt <= 4'h0;
        end else if (guardPeriod == fpcd_pkg::GUARD_OFF || standbyRelease || guardExpire ||
                     (state == fpcd_pkg::FPCD_CFG1 && rxByteValid)) begin
            guardCnt <= 4'h0;
        end else if (secTick) begin
            guardCnt <= guardCnt + 4'h1;
        end
    end

    // Standby line toward the host
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            host_standby_line <= 1'b0;
            standbyPrev <= 1'b0;
        end else begin
            standbyPrev <= host_standby_line;
            if ((guardExpire && guardStandbyEn) || standbyReq) begin
                host_standby_line <= 1'b1;
            end else if (wakeReq) begin
                host_standby_line <= 1'b0;
            end
        end
    end

    assign standbyRelease = standbyPrev && !host_standby_line;

    // Hot keys wait for the host after standby release; a read arriving with expiry still wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hotKeyPending <= 1'b0;
        end else if (standbyRelease) begin
            hotKeyPending <= 1'b1;
        end else if (keyReadEn || guardExpire) begin
            hotKeyPending <= 1'b0;
        end
    end

    assign hotKeyClear = hotKeyPending && guardExpire && !keyReadEn;

    fpcd_key_store #(
        .LINES(fpcd_pkg::KEY_LINES)
    ) u_key_store (
        .clk(clk),
        .rst_b(rst_b),
        .wrEn(keyScanStrobe),
        .wrLine(keyScanLine),
        .wrA(key_return_input_a),
        .wrB(key_return_input_b),
        .clear(hotKeyClear),
        .rdEn(keyReadEn),
        .rdAddr(keyReadAddr),
        .rdData(keyReadData)
    );

    // General pins: two-stage sync, then a stability filter of the minimum pulse width
    assign pinRaw = {general_pin_one_in, general_pin_zero_in};

    generate
        for (genvar g = 0; g < fpcd_pkg::GPIO_PINS; g++) begin : g_pin
            logic syncA;
            logic syncB;
            logic level;
            logic [7:0] stableCnt;
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    syncA <= 1'b0;
                    syncB <= 1'b0;
                end else begin
                    syncA <= pinRaw[g];
                    syncB <= syncA;
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    level <= 1'b0;
                    stableCnt <= 8'h00;
                end else if (syncB == level) begin
                    stableCnt <= 8'h00;
                end else if (stableCnt == 8'(FILT_CYC - 1)) begin
                    level <= syncB;
                    stableCnt <= 8'h00;
                end else begin
                    stableCnt <= stableCnt + 8'h01;
                end
            end
            assign pinEdge[g] = (stableCnt == 8'(FILT_CYC - 1)) && (syncB != level) && !gpioDirOut[g] &&
                                (syncB == gpioRiseEdge[g]);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gpioIrq <= 1'b0;
        end else begin
            gpioIrq <= gpioIrqEn && (pinEdge != 2'h0);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            general_pin_zero_out <= 1'b0;
            general_pin_one_out <= 1'b0;
        end else begin
            general_pin_zero_out <= gpioOutData[0];
            general_pin_one_out <= gpioOutData[1];
        end
    end

    assign general_pin_zero_oe_b = !gpioDirOut[0];
    assign general_pin_one_oe_b = !gpioDirOut[1];

    // Checks
    sequence s_cfgCmd;
        cmdTaken && rxByte[7:6] == 2'h0 && !slaveAddrMatch && !stopSeen;
    endsequence

    sequence s_byte1;
        state == fpcd_pkg::FPCD_CFG1 && rxByteValid && !slaveAddrMatch && !stopSeen;
    endsequence

    property p_cmdAfterAddr;
        @(posedge clk) disable iff (!rst_b)
        slaveAddrMatch && !stopSeen |=> state == fpcd_pkg::FPCD_CMD;
    endproperty
    a_cmdAfterAddr: assert property (p_cmdAfterAddr) else $error("command not expected after address");

    property p_idleIgnore;
        @(posedge clk) disable iff (!rst_b)
        state == fpcd_pkg::FPCD_IDLE && rxByteValid && !slaveAddrMatch |=> $stable(remoteProtocol) &&
            $stable(digitCount) && state == fpcd_pkg::FPCD_IDLE;
    endproperty
    a_idleIgnore: assert property (p_idleIgnore) else $error("byte without address changed state");

    property p_cfgDecode;
        @(posedge clk) disable iff (!rst_b)
        s_cfgCmd |=> state == fpcd_pkg::FPCD_CFG1 && guardStandbyEn == $past(rxByte[0]) &&
            wakePinEn == $past(rxByte[5]);
    endproperty
    a_cfgDecode: assert property (p_cfgDecode) else $error("config command not decoded");

    property p_setting1;
        @(posedge clk) disable iff (!rst_b)
        s_cfgCmd ##[1:40] s_byte1 |=>
            remoteProtocol == $past(rxByte[6:4]) && guardPeriod == $past(rxByte[3:0]) &&
            state == fpcd_pkg::FPCD_CFG2;
    endproperty
    a_setting1: assert property (p_setting1) else $error("first setting byte not applied");

    property p_dataCmd;
        @(posedge clk) disable iff (!rst_b)
        cmdTaken && rxByte[7:6] == 2'h1 |=> dataCmdStrobe ##1 !dataCmdStrobe;
    endproperty
    a_dataCmd: assert property (p_dataCmd) else $error("data command strobe wrong");

    property p_digitBlank;
        @(posedge clk) disable iff (!rst_b)
        $changed(digitCount) |-> !displayOn;
    endproperty
    a_digitBlank: assert property (p_digitBlank) else $error("display left on at digit change");

    property p_firstOff;
        @(posedge clk) disable iff (!rst_b)
        cmdTaken && !firstCmdDone |=> guardPeriod == 4'h0;
    endproperty
    a_firstOff: assert property (p_firstOff) else $error("guard not stopped by first command");

    property p_guardStby;
        @(posedge clk) disable iff (!rst_b)
        guardExpire && guardStandbyEn && !wakeReq |=> host_standby_line;
    endproperty
    a_guardStby: assert property (p_guardStby) else $error("guard expiry did not assert standby");

    property p_blank;
        @(posedge clk) disable iff (!rst_b)
        slaveAddrMatch && !stopSeen && clockDisplayEn && !host_standby_line |=>
            clockDisplayBlank || host_standby_line;
    endproperty
    a_blank: assert property (p_blank) else $error("clock display not blanked on write");

    property p_irqNeedsEn;
        @(posedge clk) disable iff (!rst_b)
        gpioIrq |-> $past(gpioIrqEn);
    endproperty
    a_irqNeedsEn: assert property (p_irqNeedsEn) else $error("pin interrupt while disabled");

    property p_hotClear;
        @(posedge clk) disable iff (!rst_b)
        hotKeyClear |=> ##1 keyReadData == 8'h00 || !$past(keyReadEn);
    endproperty
    a_hotClear: assert property (p_hotClear) else $error("hot keys not cleared");
endmodule // fpcd_front_panel_decoder

// file: tb/fpcd_host_model.sv
// Host side model: drives write transfers into the decoder byte port
`timescale 1ns/1ps
module fpcd_host_model (
    input wire logic clk,
    output logic slaveAddrMatch,
    output logic rxByteValid,
    output logic [7:0] rxByte,
    output logic stopSeen
);
    initial begin
        slaveAddrMatch = 1'b0;
        rxByteValid = 1'b0;
        rxByte = 8'hA5;
        stopSeen = 1'b0;
    end
    // Without addr the bytes go out unaddressed and no stop follows
    task automatic send(input logic addr, input logic [23:0] b, input int n);
        @(negedge clk);
        slaveAddrMatch = addr;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            slaveAddrMatch = 1'b0;
            rxByteValid = 1'b1;
            rxByte = b[8*i +: 8];
        end
        @(negedge clk);
        rxByteValid = 1'b0;
        // Inverted so a stale byte is never mistaken for a held one
        rxByte = ~rxByte;
        stopSeen = addr;
        @(negedge clk);
        stopSeen = 1'b0;
    endtask
endmodule // fpcd_host_model

// file: tb/tb_top.sv
// Self-checking bench for the configuration command decoder
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_b, slaveAddrMatch, rxByteValid, stopSeen, displayOnReq, standbyReq, wakeReq, keyScanStrobe;
    logic key_return_input_a, key_return_input_b, keyReadEn, keyReadAddr, general_pin_zero_in, general_pin_one_in;
    logic gpioIrq, dataCmdStrobe, host_standby_line, wakePinEn, clockDisplayEn, remoteHotKeys, guardStandbyEn;
    logic remoteRawFormat, displayOn, keyScanOn, pushPullOut, gpioIrqEn;
    logic [7:0] rxByte, keyReadData, eS1, eS2;
    logic [15:0] hotKeyMask, frontHotKeyEn;
    logic [2:0] keyScanLine, remoteProtocol;
    logic [1:0] gpioOutData, oeB, digitCount, gpioDirOut, gpioRiseEdge, pinOut;
    logic [5:0] dataCmdBits, eCmd, eBits;
    logic [3:0] guardPeriod;
    logic eDon, firstDone, blank;
    int errTotal, comparisons, eStrobe;
    int strobeCnt = 0;
    int irqCnt = 0;

    fpcd_host_model hm (.clk, .slaveAddrMatch, .rxByteValid, .rxByte, .stopSeen);
    fpcd_front_panel_decoder #(.SECOND_CYC(20), .FILT_CYC(8)) dut (
        .clk, .rst_b, .slaveAddrMatch, .rxByteValid, .rxByte, .stopSeen, .displayOnReq, .standbyReq,
        .wakeReq, .hotKeyMask, .keyScanStrobe, .keyScanLine, .key_return_input_a, .key_return_input_b,
        .keyReadEn, .keyReadAddr, .keyReadData, .general_pin_zero_in, .general_pin_one_in, .gpioOutData,
        .general_pin_zero_out(pinOut[0]), .general_pin_one_out(pinOut[1]), .general_pin_zero_oe_b(oeB[0]),
        .general_pin_one_oe_b(oeB[1]), .gpioIrq, .dataCmdStrobe, .dataCmdBits, .host_standby_line,
        .wakePinEn, .clockDisplayEn, .clockDisplayBlank(blank), .remoteHotKeys, .frontHotKeyEn, .guardStandbyEn,
        .remoteProtocol, .remoteRawFormat, .guardPeriod, .digitCount, .displayOn, .keyScanOn, .pushPullOut,
        .gpioDirOut, .gpioIrqEn, .gpioRiseEdge
    );

    always #50 clk = ~clk;
    always @(posedge clk) begin
        strobeCnt <= strobeCnt + (dataCmdStrobe === 1'b1);
        irqCnt <= irqCnt + (gpioIrq === 1'b1);
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic checkAll();
        check({wakePinEn, clockDisplayEn, remoteHotKeys, guardStandbyEn}, {eCmd[5], eCmd[3:2], eCmd[0]});
        check(frontHotKeyEn, eCmd[1] ? 16'hFFFF : hotKeyMask);
        check({remoteRawFormat, remoteProtocol, guardPeriod}, eS1);
        check({gpioRiseEdge, gpioIrqEn, gpioDirOut, pushPullOut, digitCount}, eS2);
        check({oeB, displayOn}, {~eS2[4:3], eDon});
        check({dataCmdBits, strobeCnt[7:0]}, {eBits, eStrobe[7:0]});
        check({pinOut, blank}, {gpioOutData, 1'b0});
    endtask

    // Expected settings follow each transfer; a stop after fewer bytes keeps the rest
    task automatic xfer(input logic addr, input logic [23:0] b, input int n);
        hm.send(addr, b, n);
        if (addr) begin
            if (!firstDone) eS1[3:0] = 4'h0;
            firstDone = 1'b1;
            eBits = b[5:0];
            eStrobe += (b[7:6] == 2'h1);
            if (b[7:6] == 2'h0) begin
                eCmd = b[5:0];
                if (n > 1) eS1 = b[15:8];
                if (n > 2) eS2[7:2] = b[23:18];
                if (n > 2 && b[4] && b[17:16] != eS2[1:0]) begin
                    eS2[1:0] = b[17:16];
                    eDon = 1'b0;
                end
            end
        end
        repeat (2) @(negedge clk);
        checkAll();
    endtask

    task automatic keyWrite(input logic [2:0] line, input logic a, input logic bb);
        @(negedge clk);
        {keyScanStrobe, keyScanLine, key_return_input_a, key_return_input_b} = {1'b1, line, a, bb};
        @(negedge clk);
        keyScanStrobe = 1'b0;
    endtask

    task automatic keyRead(input logic addr, input logic [7:0] exp);
        @(negedge clk);
        {keyReadEn, keyReadAddr} = {1'b1, addr};
        @(negedge clk);
        keyReadEn = 1'b0;
        check({8'h0, keyReadData}, {8'h0, exp});
    endtask

    // Pin levels are held at least the filter span unless a glitch is intended
    task automatic pin(input logic p, input logic v, input int cyc);
        @(negedge clk);
        if (p) general_pin_one_in = v;
        else general_pin_zero_in = v;
        repeat (cyc) @(negedge clk);
    endtask

    task automatic reportAndStop();
        $display("comparisons=%0d mismatches=%0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #3000000;
        errTotal++;
        reportAndStop();
    end

    initial begin
        logic [31:0] r;
        logic [23:0] b;
        int base;
        {clk, rst_b, displayOnReq, standbyReq, wakeReq, keyScanStrobe, keyReadEn, keyReadAddr} = 8'h00;
        {keyScanLine, key_return_input_a, key_return_input_b, general_pin_zero_in, general_pin_one_in} = 7'h00;
        {hotKeyMask, gpioOutData, errTotal, comparisons, eStrobe} = '0;
        {eCmd, eS1, eS2, eDon, firstDone, eBits} = {6'h01, 8'h2A, 8'h03, 1'b0, 1'b0, 6'h00};
        void'($urandom(32'h95c05c24));
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        checkAll();
        check({15'h0, keyScanOn}, 16'h0001);
        xfer(1'b0, 24'h3F3F3F, 3);
        xfer(1'b1, 24'h000040, 1);
        $display("test reset and first command done");
        r = $urandom;
        for (int l = 0; l < 8; l++) keyWrite(l[2:0], r[2*l], r[2*l+1]);
        keyRead(1'b0, r[7:0]);
        keyRead(1'b1, r[15:8]);
        $display("test key store done");
        xfer(1'b1, {eS2, 8'h01, 8'h01}, 3);
        for (int l = 0; l < 8; l++) keyWrite(l[2:0], 1'b1, 1'b1);
        for (int k = 0; k < 100 && host_standby_line !== 1'b1; k++) @(negedge clk);
        check({15'h0, host_standby_line}, 16'h0001);
        wakeReq = 1'b1;
        @(negedge clk);
        wakeReq = 1'b0;
        repeat (60) @(negedge clk);
        keyRead(1'b0, 8'h00);
        $display("test hot key timeout done");
        xfer(1'b1, {8'h60, eS1, 8'h00}, 3);
        base = irqCnt;
        pin(1'b0, 1'b1, 5);
        pin(1'b0, 1'b0, 14);
        pin(1'b0, 1'b1, 14);
        pin(1'b0, 1'b0, 14);
        pin(1'b1, 1'b1, 14);
        pin(1'b1, 1'b0, 14);
        check(16'(irqCnt - base), 16'h0002);
        $display("test pin edges done");
        for (int i = 0; i < 40; i++) begin
            r = $urandom;
            b = 24'($urandom);
            b[7:6] = {1'b0, r[21] & r[22]};
            {hotKeyMask, gpioOutData} = r[17:0];
            @(negedge clk);
            // Wake as well, so that random transfers also run with standby low
            {displayOnReq, wakeReq} = 2'h3;
            @(negedge clk);
            {displayOnReq, wakeReq} = 2'h0;
            eDon = 1'b1;
            xfer(r[20:18] != 3'h0, b, 1 + int'(r[24:23]) % 3);
        end
        $display("test random transfers done");
        reportAndStop();
    end
endmodule // tb_top
